// ==== design/ltal_alert_logic.sv ====
// threshold comparison, limit flags and open-drain alert pin with register port
`timescale 1ns/1ps
`default_nettype none
// Operation
// - high flag sets after selected run of results above the high limit
// - low flag sets after selected run of results below the low limit
// - high flag bit 6, low flag bit 5, read-only, reset zero
// - reporting style bit 4, read/write, resets to 1, governs pin and flags
// - style 0: flags follow the comparison, pin set by a high run and cleared by a low run, no clearing needed
// - style 1: pin and flags stay asserted until the host clears them
// - polarity bit 3 resets 0; when 0 an event pulls the pin low
// - polarity 1: an event releases the pin for the external pull-up
// - mask bit 2 resets 0; with manual range, reported exponent reads zero
// - masking touches only the reported result, never the comparisons
// - fault code 00..11 needs 1, 2, 4 or 8 consecutive faults; resets 00
// - result and limits compared on a common mantissa-shifted-by-exponent scale
module ltal_alert_logic
   import ltal_pkg::*;
#(
   parameter int CNT_W = 4,
   parameter int LIN_W = 27
) (
   input wire logic core_clk, // clock, 50 MHz
   input wire logic srst, // sync reset, active high
   input wire logic convDone, // pulse: new result on convResult
   input wire logic [15:0] convResult, // raw conversion result
   input wire logic [7:0] regAddr, // register pointer from the link
   input wire logic regWrite, // pulse: write regWdata
   input wire logic regRead, // pulse: read register
   input wire logic [15:0] regWdata, // write data
   output logic [15:0] regRdata, // read data, valid with regRvalid
   output logic regRvalid, // pulse: regRdata valid
   output logic intOut, // alert pin drive value, always low
   output logic intOe, // alert pin pull-down enable
   output logic highLimitFlag, // high flag state
   output logic lowLimitFlag // low flag state
);

   // register state
   logic [15:0] resultReg;
   logic [15:0] resultNext;
   logic [15:0] lowReg;
   logic [15:0] lowNext;
   logic [15:0] highReg;
   logic [15:0] highNext;
   logic [3:0] rangeSelReg;
   logic [3:0] rangeSelNext;
   logic latchSelReg;
   logic latchSelNext;
   logic polReg;
   logic polNext;
   logic expMaskReg;
   logic expMaskNext;
   logic [1:0] faultSelReg;
   logic [1:0] faultSelNext;
   logic highFlagReg;
   logic highFlagNext;
   logic lowFlagReg;
   logic lowFlagNext;
   logic alertReg;
   logic alertNext;
   logic [15:0] rdataReg;
   logic [15:0] rdataNext;
   logic rvalidReg;
   logic intOeReg;

   // decode
   wire logic hitResult;
   wire logic hitConfig;
   wire logic hitLow;
   wire logic hitHigh;
   wire logic cfgWrite;
   wire logic cfgRead;
   wire logic lowWrite;
   wire logic highWrite;
   wire logic hostClear;
   wire logic maskActive;
   wire logic [15:0] resultView;
   wire logic [15:0] configView;
   wire logic [15:0] readMux;

   // comparison
   wire logic aboveHigh;
   wire logic belowHigh;
   wire logic aboveLow;
   wire logic belowLow;
   wire logic highTrip;
   wire logic lowTrip;

   assign hitResult = regAddr == REG_RESULT_ADDR;
   assign hitConfig = regAddr == REG_CONFIG_ADDR;
   assign hitLow = regAddr == REG_LOW_ADDR;
   assign hitHigh = regAddr == REG_HIGH_ADDR;
   assign cfgWrite = regWrite && hitConfig;
   assign cfgRead = regRead && hitConfig;
   assign lowWrite = regWrite && hitLow;
   assign highWrite = regWrite && hitHigh;

   // reading config_control is the clearing action in latched style
   assign hostClear = cfgRead;

   // comparisons see the raw conversion, never the masked view
   ltal_lux_compare #(
      .LIN_W(LIN_W)
   ) highCmp (
      .valueA(convResult),
      .valueB(highReg),
      .aAbove(aboveHigh),
      .aBelow(belowHigh)
   );

   ltal_lux_compare #(
      .LIN_W(LIN_W)
   ) lowCmp (
      .valueA(convResult),
      .valueB(lowReg),
      .aAbove(aboveLow),
      .aBelow(belowLow)
   );

   ltal_fault_counter #(
      .CNT_W(CNT_W)
   ) highRun (
      .core_clk(core_clk),
      .srst(srst),
      .sample(convDone),
      .violation(aboveHigh),
      .faultSel(faultSelReg),
      .trip(highTrip)
   );

   ltal_fault_counter #(
      .CNT_W(CNT_W)
   ) lowRun (
      .core_clk(core_clk),
      .srst(srst),
      .sample(convDone),
      .violation(belowLow),
      .faultSel(faultSelReg),
      .trip(lowTrip)
   );

   // reported result: exponent zeroed under manual range with mask on
   assign maskActive = expMaskReg && (rangeSelReg < RANGE_AUTO);
   assign resultView = maskActive ? {EXP_ZERO, resultReg[MANT_MSB:MANT_LSB]} : resultReg;

   assign configView = {rangeSelReg, 5'h00, highFlagReg, lowFlagReg, latchSelReg, polReg,
                        expMaskReg, faultSelReg};

   // unmapped pointers read zero
   assign readMux = hitResult ? resultView :
                    hitConfig ? configView :
                    hitLow ? lowReg :
                    hitHigh ? highReg : READ_ZERO;

   assign resultNext = convDone ? convResult : resultReg;
   assign lowNext = lowWrite ? regWdata : lowReg;
   assign highNext = highWrite ? regWdata : highReg;
   assign rangeSelNext = cfgWrite ? regWdata[CFG_RANGE_MSB:CFG_RANGE_LSB] : rangeSelReg;
   assign latchSelNext = cfgWrite ? regWdata[CFG_LATCH_BIT] : latchSelReg;
   assign polNext = cfgWrite ? regWdata[CFG_POL_BIT] : polReg;
   assign expMaskNext = cfgWrite ? regWdata[CFG_MASK_BIT] : expMaskReg;
   assign faultSelNext = cfgWrite ? regWdata[CFG_FAULT_MSB:CFG_FAULT_LSB] : faultSelReg;
   assign rdataNext = regRead ? readMux : rdataReg;

   // flags and alert state; a trip in the clearing cycle wins
   always_comb begin
      highFlagNext = highFlagReg;
      lowFlagNext = lowFlagReg;
      alertNext = alertReg;
      if (latchSelReg) begin
         highFlagNext = highTrip || (highFlagReg && !hostClear);
         lowFlagNext = lowTrip || (lowFlagReg && !hostClear);
         alertNext = highTrip || lowTrip || (alertReg && !hostClear);
      end else begin
         if (highTrip) begin
            highFlagNext = 1'b1;
         end else if (convDone && !aboveHigh) begin
            highFlagNext = 1'b0;
         end
         if (lowTrip) begin
            lowFlagNext = 1'b1;
         end else if (convDone && !belowLow) begin
            lowFlagNext = 1'b0;
         end
         // hysteresis: high run asserts, low run deasserts
         if (highTrip) begin
            alertNext = 1'b1;
         end else if (lowTrip) begin
            alertNext = 1'b0;
         end
      end
   end

   always_ff @(posedge core_clk) begin
      if (srst) begin
         resultReg <= RESULT_RESET;
         lowReg <= LOW_RESET;
         highReg <= HIGH_RESET;
         rangeSelReg <= RANGE_RESET;
         latchSelReg <= LATCH_RESET;
         polReg <= POL_RESET;
         expMaskReg <= MASK_RESET;
         faultSelReg <= FAULT_SEL_RESET;
      end else begin
         resultReg <= resultNext;
         lowReg <= lowNext;
         highReg <= highNext;
         rangeSelReg <= rangeSelNext;
         latchSelReg <= latchSelNext;
         polReg <= polNext;
         expMaskReg <= expMaskNext;
         faultSelReg <= faultSelNext;
      end
   end

   always_ff @(posedge core_clk) begin
      if (srst) begin
         highFlagReg <= 1'b0;
         lowFlagReg <= 1'b0;
         alertReg <= 1'b0;
         intOeReg <= POL_RESET;
         rdataReg <= READ_ZERO;
         rvalidReg <= 1'b0;
      end else begin
         highFlagReg <= highFlagNext;
         lowFlagReg <= lowFlagNext;
         alertReg <= alertNext;
         intOeReg <= alertNext ^ polNext;
         rdataReg <= rdataNext;
         rvalidReg <= regRead;
      end
   end

   // pin never drives high: released or pulled low only
   assign intOut = 1'b0;
   assign intOe = intOeReg;
   assign regRdata = rdataReg;
   assign regRvalid = rvalidReg;
   assign highLimitFlag = highFlagReg;
   assign lowLimitFlag = lowFlagReg;

   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (srst);

   high_flag_set_a: assert property (
      convDone && aboveHigh && faultSelReg == 2'h0 |=> highFlagReg)
      else $error("high flag not set after one fault");

   low_flag_set_a: assert property (
      convDone && belowLow && faultSelReg == 2'h0 |=> lowFlagReg)
      else $error("low flag not set after one fault");

   flag_read_view_a: assert property (
      regRead && hitConfig |=> regRvalid && regRdata[CFG_HIGH_FLAG_BIT] == $past(highFlagReg)
         && regRdata[CFG_LOW_FLAG_BIT] == $past(lowFlagReg))
      else $error("config read shows wrong flag bits");

   style_reset_a: assert property (
      $fell(srst) |-> latchSelReg == LATCH_RESET && polReg == POL_RESET
         && expMaskReg == MASK_RESET && faultSelReg == FAULT_SEL_RESET && !highFlagReg && !lowFlagReg)
      else $error("config fields wrong after reset");

   transparent_clear_a: assert property (
      !latchSelReg && convDone && !aboveHigh |=> !highFlagReg)
      else $error("transparent high flag did not follow comparison");

   latched_hold_a: assert property (
      latchSelReg && highFlagReg && !hostClear |=> highFlagReg)
      else $error("latched high flag dropped without clearing");

   low_flag_clear_a: assert property (
      !latchSelReg && convDone && !belowLow |=> !lowFlagReg)
      else $error("transparent low flag did not follow comparison");

   alert_hold_a: assert property (
      latchSelReg && alertReg && !hostClear |=> alertReg)
      else $error("latched alert dropped without clearing");

   pin_polarity_a: assert property (
      ##1 intOe == (alertReg ^ polReg))
      else $error("alert pin enable disagrees with polarity");

   pin_release_a: assert property (
      polReg && alertReg |-> !intOe && !intOut)
      else $error("alert pin not released under inverted polarity");

   exp_mask_a: assert property (
      regRead && hitResult && maskActive |=> regRdata[EXP_MSB:EXP_LSB] == EXP_ZERO)
      else $error("masked exponent not zero");

   compare_unmasked_a: assert property (
      regRead && hitResult && !maskActive |=> regRdata == $past(resultReg))
      else $error("unmasked result read wrong");

   fault_eight_a: assert property (
      !latchSelReg && faultSelReg == 2'h3 && convDone && !aboveHigh ##[1:7]
         !latchSelReg && faultSelReg == 2'h3 && convDone && aboveHigh && !highFlagReg
         |=> !highFlagReg)
      else $error("high flag set before eight faults");

endmodule : ltal_alert_logic
`default_nettype wire

// ==== design/ltal_fault_counter.sv ====
// counts consecutive limit violations and trips at the selected count
`timescale 1ns/1ps
`default_nettype none
module ltal_fault_counter
   import ltal_pkg::*;
#(
   parameter int CNT_W = 4
) (
   input wire logic core_clk, // clock
   input wire logic srst, // sync reset, active high
   input wire logic sample, // conversion finished
   input wire logic violation, // result beyond this limit
   input wire logic [1:0] faultSel, // consecutive count code
   output logic trip // reached count on this sample
);

   logic [CNT_W-1:0] cntReg;
   logic [CNT_W-1:0] cntNext;
   wire logic [CNT_W-1:0] cntPlus;
   wire logic [CNT_W-1:0] needed;

   // code 0..3 selects 1, 2, 4 or 8
   function automatic logic [CNT_W-1:0] neededCount(input logic [1:0] sel);
      neededCount = {{(CNT_W-1){1'b0}}, 1'b1} << sel;
   endfunction : neededCount

   assign needed = neededCount(faultSel);
   assign cntPlus = cntReg + {{(CNT_W-1){1'b0}}, 1'b1};
   assign trip = sample && violation && (cntPlus >= needed);

   // saturate at the needed count; a passing sample restarts the run
   always_comb begin
      cntNext = cntReg;
      if (sample) begin
         if (!violation) begin
            cntNext = '0;
         end else if (cntReg < needed) begin
            cntNext = cntPlus;
         end
      end
   end

   always_ff @(posedge core_clk) begin
      if (srst) begin
         cntReg <= '0;
      end else begin
         cntReg <= cntNext;
      end
   end

endmodule : ltal_fault_counter
`default_nettype wire

// ==== design/ltal_lux_compare.sv ====
// scales two exponent/mantissa values to a common base and compares them
`timescale 1ns/1ps
`default_nettype none
module ltal_lux_compare
   import ltal_pkg::*;
#(
   parameter int LIN_W = 27
) (
   input wire logic [15:0] valueA, // value under test
   input wire logic [15:0] valueB, // limit
   output logic aAbove, // valueA greater than valueB
   output logic aBelow // valueA less than valueB
);

   wire logic [LIN_W-1:0] linA;
   wire logic [LIN_W-1:0] linB;

   // mantissa shifted by exponent gives a common 0.01-unit scale
   assign linA = LIN_W'(valueA[MANT_MSB:MANT_LSB]) << valueA[EXP_MSB:EXP_LSB];
   assign linB = LIN_W'(valueB[MANT_MSB:MANT_LSB]) << valueB[EXP_MSB:EXP_LSB];
   assign aAbove = linA > linB;
   assign aBelow = linA < linB;

endmodule : ltal_lux_compare
`default_nettype wire

// ==== design/ltal_pkg.sv ====
// shared constants for the light threshold alert logic
package ltal_pkg;

   // register pointer values
   localparam logic [7:0] REG_RESULT_ADDR = 8'h00;
   localparam logic [7:0] REG_CONFIG_ADDR = 8'h01;
   localparam logic [7:0] REG_LOW_ADDR = 8'h02;
   localparam logic [7:0] REG_HIGH_ADDR = 8'h03;

   // reset values
   localparam logic [15:0] RESULT_RESET = 16'h0000;
   localparam logic [15:0] LOW_RESET = 16'h0000;
   localparam logic [15:0] HIGH_RESET = 16'hBFFF;
   localparam logic [15:0] READ_ZERO = 16'h0000;
   localparam logic [3:0] RANGE_RESET = 4'hC;
   localparam logic LATCH_RESET = 1'b1;
   localparam logic POL_RESET = 1'b0;
   localparam logic MASK_RESET = 1'b0;
   localparam logic [1:0] FAULT_SEL_RESET = 2'h0;

   // encodings
   localparam logic [3:0] RANGE_AUTO = 4'hC;
   localparam logic [3:0] EXP_ZERO = 4'h0;

   // value layout: exponent over mantissa
   localparam int EXP_MSB = 15;
   localparam int EXP_LSB = 12;
   localparam int MANT_MSB = 11;
   localparam int MANT_LSB = 0;

   // config_control layout
   localparam int CFG_RANGE_MSB = 15;
   localparam int CFG_RANGE_LSB = 12;
   localparam int CFG_HIGH_FLAG_BIT = 6;
   localparam int CFG_LOW_FLAG_BIT = 5;
   localparam int CFG_LATCH_BIT = 4;
   localparam int CFG_POL_BIT = 3;
   localparam int CFG_MASK_BIT = 2;
   localparam int CFG_FAULT_MSB = 1;
   localparam int CFG_FAULT_LSB = 0;

endpackage : ltal_pkg

// ==== dv/ltal_host_model.sv ====
// host-side model: register access strobes and the alert pin pull-up
`timescale 1ns/1ps
`default_nettype none
module ltal_host_model (
   input wire logic core_clk, // clock
   input wire logic [15:0] regRdata, // read data from the block
   input wire logic regRvalid, // read data strobe
   input wire logic intOut, // alert pin drive value
   input wire logic intOe, // alert pin pull-down enable
   output logic [7:0] regAddr, // register pointer
   output logic regWrite, // write strobe
   output logic regRead, // read strobe
   output logic [15:0] regWdata, // write data
   output logic alertPin, // resolved pin level
   output logic timedOut // a read answer never came
);
   // external pull-up wins whenever the block lets go of the pin
   assign alertPin = intOe ? intOut : 1'b1;

   initial begin
      regAddr = 8'h00;
      regWrite = 1'b0;
      regRead = 1'b0;
      regWdata = 16'h0000;
      timedOut = 1'b0;
   end

   task automatic writeReg(input logic [7:0] addr, input logic [15:0] data);
      @(posedge core_clk);
      regAddr <= addr;
      regWdata <= data;
      regWrite <= 1'b1;
      @(posedge core_clk);
      regWrite <= 1'b0;
      // data no longer qualified, so it must not keep looking valid
      regWdata <= ~data;
   endtask : writeReg

   task automatic readReg(input logic [7:0] addr, output logic [15:0] data);
      int i;
      data = 16'h0000;
      @(posedge core_clk);
      regAddr <= addr;
      regRead <= 1'b1;
      @(posedge core_clk);
      regRead <= 1'b0;
      i = 0;
      do begin
         @(posedge core_clk);
         i++;
      end while (regRvalid !== 1'b1 && i < 4);
      if (regRvalid !== 1'b1) begin
         timedOut = 1'b1;
      end
      data = regRdata;
   endtask : readReg
endmodule : ltal_host_model
`default_nettype wire

// ==== dv/test_light_threshold_alert_logic.sv ====
// self-checking bench for the light threshold alert logic
`timescale 1ns/1ps
`default_nettype none
module test_light_threshold_alert_logic;
   import ltal_pkg::*;
   logic core_clk = 1'b0;
   logic srst = 1'b1;
   logic convDone = 1'b0;
   logic [15:0] convResult = 16'h0000;
   logic [7:0] regAddr;
   logic regWrite, regRead, regRvalid, intOut, intOe;
   logic highLimitFlag, lowLimitFlag, alertPin, timedOut;
   logic [15:0] regWdata, regRdata;
   int miscompares = 0;
   int nTests = 0;
   int cycles = 0;

   always #10 core_clk = ~core_clk;

   ltal_alert_logic dut (.core_clk(core_clk), .srst(srst), .convDone(convDone),
      .convResult(convResult), .regAddr(regAddr), .regWrite(regWrite), .regRead(regRead),
      .regWdata(regWdata), .regRdata(regRdata), .regRvalid(regRvalid), .intOut(intOut),
      .intOe(intOe), .highLimitFlag(highLimitFlag), .lowLimitFlag(lowLimitFlag));

   ltal_host_model host (.core_clk(core_clk), .regRdata(regRdata), .regRvalid(regRvalid),
      .intOut(intOut), .intOe(intOe), .regAddr(regAddr), .regWrite(regWrite),
      .regRead(regRead), .regWdata(regWdata), .alertPin(alertPin), .timedOut(timedOut));

   task automatic check(input logic [15:0] got, input logic [15:0] exp);
      nTests++;
      if (got !== exp) begin
         miscompares++;
         $display("ERROR at %0t ns: got %h expected %h", $time, got, exp);
      end
   endtask : check

   task automatic readCheck(input logic [7:0] addr, input logic [15:0] exp);
      logic [15:0] v;
      host.readReg(addr, v);
      check(v, exp);
   endtask : readCheck

   // one conversion pulse, then one edge so the flag update is visible
   task automatic conv(input logic [15:0] v);
      @(posedge core_clk);
      convDone <= 1'b1;
      convResult <= v;
      @(posedge core_clk);
      convDone <= 1'b0;
      convResult <= ~v;
      @(posedge core_clk);
   endtask : conv

   task automatic flags(input logic hi, input logic lo, input logic pin);
      check({13'h0000, highLimitFlag, lowLimitFlag, alertPin}, {13'h0000, hi, lo, pin});
   endtask : flags

   task automatic complete_run;
      $display("comparisons %0d, mismatches %0d", nTests, miscompares);
      if (miscompares == 0 && nTests > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask : complete_run

   always @(posedge core_clk) begin
      cycles++;
      if (cycles == 3000) begin
         miscompares++;
         complete_run();
      end
   end

   initial begin
      repeat (2) @(posedge core_clk);
      srst <= 1'b0;
      flags(1'b0, 1'b0, 1'b1);
      readCheck(REG_CONFIG_ADDR, 16'hC010);
      readCheck(REG_LOW_ADDR, 16'h0000);
      readCheck(REG_HIGH_ADDR, 16'hBFFF);
      readCheck(REG_RESULT_ADDR, 16'h0000);
      readCheck(8'h10, 16'h0000);
      host.writeReg(REG_CONFIG_ADDR, 16'hC070);
      readCheck(REG_CONFIG_ADDR, 16'hC010);
      // high limit with an exponent unlike the results': 4096 high, 256 low
      host.writeReg(REG_HIGH_ADDR, 16'h1800);
      host.writeReg(REG_LOW_ADDR, 16'h0100);
      conv(16'h0FFF);
      flags(1'b0, 1'b0, 1'b1);
      conv(16'h2401);
      flags(1'b1, 1'b0, 1'b0);
      conv(16'h0FFF);
      flags(1'b1, 1'b0, 1'b0);
      readCheck(REG_CONFIG_ADDR, 16'hC050);
      flags(1'b0, 1'b0, 1'b1);
      for (int code = 0; code < 4; code++) begin
         host.writeReg(REG_CONFIG_ADDR, 16'hC010 | 16'(code));
         readCheck(REG_CONFIG_ADDR, 16'hC010 | 16'(code));
         conv(16'h0FFF);
         repeat ((1 << code) - 1) begin
            conv(16'h2401);
            flags(1'b0, 1'b0, 1'b1);
         end
         conv(16'h2401);
         flags(1'b1, 1'b0, 1'b0);
         readCheck(REG_CONFIG_ADDR, 16'hC050 | 16'(code));
      end
      host.writeReg(REG_CONFIG_ADDR, 16'hC000);
      conv(16'h00FF);
      flags(1'b0, 1'b1, 1'b1);
      conv(16'h0100);
      flags(1'b0, 1'b0, 1'b1);
      conv(16'h2401);
      flags(1'b1, 1'b0, 1'b0);
      conv(16'h0FFF);
      flags(1'b0, 1'b0, 1'b0);
      conv(16'h00FF);
      flags(1'b0, 1'b1, 1'b1);
      // transparent style, eight-fault code: a short run must not trip
      host.writeReg(REG_CONFIG_ADDR, 16'hC003);
      conv(16'h0FFF);
      conv(16'h2401);
      flags(1'b0, 1'b0, 1'b1);
      host.writeReg(REG_CONFIG_ADDR, 16'hC008);
      conv(16'h2401);
      flags(1'b1, 1'b0, 1'b1);
      conv(16'h00FF);
      flags(1'b0, 1'b1, 1'b0);
      // manual range with masking: comparison must still see 0x401 << 2
      host.writeReg(REG_CONFIG_ADDR, 16'hB004);
      conv(16'h2401);
      flags(1'b1, 1'b0, 1'b0);
      readCheck(REG_RESULT_ADDR, 16'h0401);
      host.writeReg(REG_RESULT_ADDR, 16'h1234);
      host.writeReg(REG_CONFIG_ADDR, 16'hC004);
      readCheck(REG_RESULT_ADDR, 16'h2401);
      // second reset mid-run: configured state must return to reset values
      @(posedge core_clk);
      srst <= 1'b1;
      repeat (2) @(posedge core_clk);
      srst <= 1'b0;
      flags(1'b0, 1'b0, 1'b1);
      readCheck(REG_CONFIG_ADDR, 16'hC010);
      readCheck(REG_HIGH_ADDR, 16'hBFFF);
      readCheck(REG_RESULT_ADDR, 16'h0000);
      check({15'h0000, timedOut}, 16'h0000);
      complete_run();
   end
endmodule : test_light_threshold_alert_logic
`default_nettype wire
